/* tb/gst2_assertions.sv */
// Purpose: Port-level checks of gst2_status
// Assumes: Each read holds rd_i for two edges
// Notes:   Bound to the design at the foot
`timescale 1ns/100ps
module gst2_assertions (
    input wire logic       mclk_i,             // Clock
    input wire logic       reset_i,            // Reset
    input wire logic [3:0] addr_i,             // Offset
    input wire logic       rd_i,               // Read
    input wire logic       cic_i,              // Controller
    input wire logic       srq_i,              // Request
    input wire logic       rqs_i,              // Poll msg
    input wire logic       dav_i,              // Valid msg
    input wire logic       cacs_i,             // Active
    input wire logic       sgns_i,             // Generate
    input wire logic       ren_i,              // Remote enable
    input wire logic [7:0] rd_data_o,          // Image
    input wire logic       service_request_in_flag_o, // Flag
    input wire logic       command_out_flag_o, // Flag
    input wire logic       lockout_level_o,    // Level
    input wire logic       remote_level_o,     // Level
    input wire logic       irq_o               // Request out
);
    import gst2_pkg::*;
    ////////////////
    wire logic rdg   = rd_i && addr_i == STAT_TWO_OFFSET;
    wire logic srq_t = cic_i && srq_i && !(rqs_i && dav_i);
    wire logic cmd_t = cacs_i && sgns_i;
    wire logic req_flag = service_request_in_flag_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence rd_start_s; !rdg ##1 rdg; endsequence
    // Controller off for the whole read, so nothing can be parked
    sequence clean_rd_s; !rdg ##1 (rdg && !cic_i) [*2] ##1 (!rd_i && !cic_i); endsequence
    srq_set_a: assert property (!rdg && $rose(srq_t) |=> req_flag)
        else $error("request-in flag missed");
    srq_cic_a: assert property ($rose(req_flag) && !$past(rdg, 2) |-> $past(cic_i))
        else $error("request-in flag without controller");
    srq_clear_a: assert property (clean_rd_s |=> !req_flag)
        else $error("request-in flag not cleared by read");
    cmd_set_a: assert property (!rdg && $rose(cmd_t) |=> command_out_flag_o)
        else $error("command out missed");
    cmd_clear_a: assert property (!rdg && !cmd_t |=> !command_out_flag_o)
        else $error("command out not cleared");
    flag_freeze_a: assert property (rdg && $past(rdg) |-> $stable(req_flag)
        && $stable(command_out_flag_o)) else $error("flag moved during read");
    no_irq_a: assert property (!req_flag && !command_out_flag_o |=> !irq_o)
        else $error("irq without flag");
    ren_off_a: assert property (!ren_i |=> !lockout_level_o && !remote_level_o)
        else $error("remote kept without enable");
    read_image_a: assert property (rd_start_s |=> rd_data_o == {1'h0, $past(req_flag),
        $past(lockout_level_o), $past(remote_level_o), $past(command_out_flag_o), 3'h0})
        else $error("read image wrong");
endmodule
bind gst2_status gst2_assertions u_chk (.*);

/* tb/gst2_bus_model.sv */
// Purpose: Far-side bus levels for gst2_status
// Assumes: Bench names the level set it wants
// Notes:   Lines move only at the falling edge, clear of the sampling edge
`timescale 1ns/100ps
module gst2_bus_model (
    input  wire logic       mclk_i, // Clock
    input  wire logic [9:0] want_i, // Requested levels
    output logic      [9:0] bus_o   // Bus levels
);
    ////////////////
    initial bus_o = 10'h000;
    always @(negedge mclk_i) begin
        bus_o <= want_i;
    end
endmodule

/* tb/tb_gst2_status.sv */
// Purpose: Register-port bench for gst2_status
// Assumes: Far-side levels come from gst2_bus_model
// Notes:   Outputs are sampled at the falling edge
`timescale 1ns/100ps
module tb_gst2_status;
    import gst2_pkg::*;
    ////////////////
    logic       mclk_i, reset_i, rd_i, wr_i, srv_in, cmd_out, lockout, remote, irq;
    logic [3:0] addr_i;
    logic [7:0] wr_data_i, rd_data;
    logic [9:0] want, bus;
    int         n_fail, check_count;
    wire logic [7:0] flags = {3'h0, irq, lockout, remote, cmd_out, srv_in};
    gst2_bus_model u_bus (.mclk_i(mclk_i), .want_i(want), .bus_o(bus));
    gst2_status dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i),
        .wr_i(wr_i), .wr_data_i(wr_data_i), .cic_i(bus[0]), .srq_i(bus[1]), .rqs_i(bus[2]),
        .dav_i(bus[3]), .cacs_i(bus[4]), .sgns_i(bus[5]), .ren_i(bus[6]),
        .listen_addr_i(bus[7]), .llo_i(bus[8]), .gtl_i(bus[9]), .rd_data_o(rd_data),
        .service_request_in_flag_o(srv_in), .command_out_flag_o(cmd_out),
        .lockout_level_o(lockout), .remote_level_o(remote), .irq_o(irq));
    ////////////////
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Three falling edges: levels applied, flags set, irq follows
    task automatic bus_set(input logic [9:0] v, input logic [7:0] exp, input string nm);
        @(posedge mclk_i);
        want = v;
        repeat (3) @(negedge mclk_i);
        chk(nm, exp, flags);
    endtask
    // Mid-read levels land while the read is open, to exercise parking
    task automatic rd(input logic [9:0] mid, input logic [7:0] exp, input string nm);
        @(negedge mclk_i);
        rd_i = 1'b1;
        addr_i = STAT_TWO_OFFSET;
        @(posedge mclk_i);
        want = mid;
        repeat (2) @(negedge mclk_i);
        chk(nm, exp, rd_data);
        rd_i = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        {wr_i, addr_i, wr_data_i} = {1'b1, a, d};
        @(negedge mclk_i);
        wr_i = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {reset_i, rd_i, wr_i, addr_i, wr_data_i, want} = {3'h4, 4'h0, 8'h00, 10'h000};
        n_fail = 0;
        check_count = 0;
        repeat (8) @(negedge mclk_i);
        reset_i = 1'b0;
        rd(want, 8'h00, "reset image");
        $display("test reset done");
        bus_set(10'h00f, 8'h00, "srq while polled");
        bus_set(10'h002, 8'h00, "srq without cic");
        bus_set(10'h003, 8'h01, "srq set");
        rd(want, 8'h40, "srq image");
        chk("srq read clear", 8'h00, flags);
        wr(STAT_TWO_OFFSET, 8'h40);
        bus_set(10'h000, 8'h00, "srq idle");
        rd(10'h003, 8'h00, "srq parked image");
        chk("srq parked", 8'h01, flags);
        @(negedge mclk_i);
        chk("srq irq", 8'h11, flags);
        bus_set(10'h000, 8'h11, "srq held off cic");
        rd(want, 8'h40, "srq parked read");
        @(negedge mclk_i);
        chk("srq irq clear", 8'h00, flags);
        $display("test srq done");
        wr(STAT_TWO_OFFSET, 8'h08);
        bus_set(10'h030, 8'h12, "cmd set");
        wr(4'h6, 8'h00);
        chk("foreign write", 8'h12, flags);
        bus_set(10'h010, 8'h00, "cmd source left");
        bus_set(10'h030, 8'h12, "cmd again");
        rd(want, 8'h08, "cmd image");
        @(negedge mclk_i);
        chk("cmd read clear", 8'h00, flags);
        bus_set(10'h010, 8'h00, "cmd idle");
        rd(10'h030, 8'h00, "cmd parked image");
        chk("cmd parked", 8'h02, flags);
        $display("test command out done");
        wr(STAT_TWO_OFFSET, 8'h48);
        bus_set(10'h0c0, 8'h04, "remote");
        rd(want, 8'h10, "remote image");
        bus_set(10'h1c0, 8'h0c, "remote lockout");
        rd(want, 8'h30, "rwls image");
        rd(want, 8'h30, "rwls reread");
        bus_set(10'h3c0, 8'h08, "local lockout");
        rd(want, 8'h20, "lwls image");
        bus_set(10'h000, 8'h00, "ren dropped");
        bus_set(10'h140, 8'h08, "lockout direct");
        bus_set(10'h0c0, 8'h0c, "lockout listened");
        bus_set(10'h000, 8'h00, "ren dropped again");
        bus_set(10'h0c0, 8'h04, "remote again");
        bus_set(10'h2c0, 8'h00, "go to local");
        $display("test remote done");
        tally_and_finish();
    end
endmodule

/* verilog/gst2_pkg.sv */
// Purpose: Constants for the second interrupt status / mask register slice
// Assumes: Byte-wide register port of the talker/listener chip, one clock
// Notes:   Bit positions hold for both the read and the write image
//
// What this block does
// - Set service-request flag on rising controller-SRQ term
// - Clear service-request flag on reset or status read
// - Service request set only while controller-in-charge
// - Lockout bit 5 reads one in LWLS/RWLS
// - Lockout bit never raises an interrupt
// - Remote bit 4 reads one in REMS/RWLS
// - Enter remote when REN and addressed listener
// - Set command-out bit 3 on CACS-and-SGNS rise
// - Clear command-out on read, leaving CACS or SGNS
// - Command-out set means command output register empty
// - Enabled status raises interrupt; status ignores enables
// - Defer flag set/clear until status read completes
package gst2_pkg;

    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;

    // Register port offset of the status (read) / mask (write) pair
    localparam logic [3:0]  STAT_TWO_OFFSET = 4'h5;

    // Read image
    localparam int          BIT_SRV_REQ     = 6;
    localparam int          BIT_LOCKOUT     = 5;
    localparam int          BIT_REMOTE      = 4;
    localparam int          BIT_CMD_OUT     = 3;
    // Write image
    localparam int          BIT_SRV_REQ_IE  = 6;
    localparam int          BIT_DMA_OUT     = 5;
    localparam int          BIT_DMA_IN      = 4;
    localparam int          BIT_CMD_OUT_IE  = 3;

    localparam logic [7:0]  STAT_RESET      = 8'h00;
    localparam logic        FLAG_RESET      = 1'b0;
    localparam logic        ENABLE_RESET    = 1'b0;

    // Remote/local function states
    typedef enum logic [1:0] {
        GST2_LOCS,
        GST2_REMS,
        GST2_RWLS,
        GST2_LWLS
    } gst2_rl_state_t;

endpackage

/* verilog/gst2_status.sv */
// Purpose: Second interrupt status/mask slice: service request in, lockout,
//          remote, command out, plus the remote/local state tracker
// Assumes: rd_i is held high for the whole read access; inputs synchronous
// Notes:   Read data is snapshotted at the start of a read access
`timescale 1ns/100ps
module gst2_status (
    input  wire logic                           mclk_i,        // 25 MHz clock
    input  wire logic                           reset_i,       // Sync reset, high
    input  wire logic [gst2_pkg::ADDR_W-1:0]    addr_i,        // Register offset
    input  wire logic                           rd_i,          // Read access level
    input  wire logic                           wr_i,          // Write strobe
    input  wire logic [gst2_pkg::DATA_W-1:0]    wr_data_i,     // Write data
    input  wire logic                           cic_i,         // Controller in charge
    input  wire logic                           srq_i,         // Bus service request
    input  wire logic                           rqs_i,         // Request service msg
    input  wire logic                           dav_i,         // Data valid msg
    input  wire logic                           cacs_i,        // Controller active state
    input  wire logic                           sgns_i,        // Source generate state
    input  wire logic                           ren_i,         // Remote enable line
    input  wire logic                           listen_addr_i, // Addressed as listener
    input  wire logic                           llo_i,         // Local lockout received
    input  wire logic                           gtl_i,         // Go to local received
    output logic      [gst2_pkg::DATA_W-1:0]    rd_data_o,     // Read data
    output logic                                service_request_in_flag_o, // Service request flag
    output logic                                command_out_flag_o, // Command out flag
    output logic                                lockout_level_o,    // Lockout status
    output logic                                remote_level_o,     // Remote status
    output logic                                irq_o          // Interrupt request
);
    import gst2_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Access decode

    logic                   sel;
    logic                   rd_act;
    logic                   rd_q_reg;
    logic                   rd_start;
    logic                   rd_end;
    logic                   wr_act;

    assign sel      = (addr_i == STAT_TWO_OFFSET);
    assign rd_act   = rd_i & sel;
    assign rd_start = rd_act & ~rd_q_reg;
    assign rd_end   = rd_q_reg & ~rd_act;
    assign wr_act   = wr_i & sel;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_q_reg <= 1'b0;
        end else begin
            rd_q_reg <= rd_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask register

    logic                   srv_req_ie_reg;
    logic                   cmd_out_ie_reg;

    // DMA enables are not implemented; their write bits are dropped
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            srv_req_ie_reg <= ENABLE_RESET;
            cmd_out_ie_reg <= ENABLE_RESET;
        end else if (wr_act) begin
            srv_req_ie_reg <= wr_data_i[BIT_SRV_REQ_IE];
            cmd_out_ie_reg <= wr_data_i[BIT_CMD_OUT_IE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event terms

    logic                   srq_term;
    logic                   srq_term_reg;
    logic                   srq_rise;
    logic                   cmd_term;
    logic                   cmd_term_reg;
    logic                   cmd_rise;

    assign srq_term = cic_i & srq_i & ~(rqs_i & dav_i);
    assign srq_rise = srq_term & ~srq_term_reg;
    assign cmd_term = cacs_i & sgns_i;
    assign cmd_rise = cmd_term & ~cmd_term_reg;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            srq_term_reg <= 1'b0;
            cmd_term_reg <= 1'b0;
        end else begin
            srq_term_reg <= srq_term;
            cmd_term_reg <= cmd_term;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Service request in flag

    logic                   srv_req_reg;
    logic                   srv_req_pend_reg;

    // During a read the flag is frozen and a new event is parked; at the
    // end of the read the clear is applied first so a parked event wins
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            srv_req_reg      <= FLAG_RESET;
            srv_req_pend_reg <= 1'b0;
        end else if (rd_act) begin
            if (srq_rise) begin
                srv_req_pend_reg <= 1'b1;
            end
        end else if (rd_end) begin
            srv_req_reg      <= srv_req_pend_reg | srq_rise;
            srv_req_pend_reg <= 1'b0;
        end else if (srq_rise) begin
            srv_req_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command out flag

    logic                   cmd_out_reg;
    logic                   cmd_out_pend_reg;

    // Set means the command output register is empty and may be written
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cmd_out_reg      <= FLAG_RESET;
            cmd_out_pend_reg <= 1'b0;
        end else if (rd_act) begin
            if (cmd_rise) begin
                cmd_out_pend_reg <= 1'b1;
            end else if (!cmd_term) begin
                cmd_out_pend_reg <= 1'b0;
            end
        end else if (rd_end) begin
            cmd_out_reg      <= (cmd_out_pend_reg | cmd_rise) & cmd_term;
            cmd_out_pend_reg <= 1'b0;
        end else if (cmd_rise) begin
            cmd_out_reg <= 1'b1;
        end else if (!cmd_term) begin
            cmd_out_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remote/local function

    gst2_rl_state_t         rl_reg;
    gst2_rl_state_t         rl_next;

    always_comb begin
        rl_next = rl_reg;
        if (!ren_i) begin
            rl_next = GST2_LOCS;
        end else begin
            unique case (rl_reg)
                GST2_LOCS: begin
                    if (llo_i) begin
                        rl_next = GST2_LWLS;
                    // A go-to-local still on the bus keeps the function local
                    end else if (listen_addr_i && !gtl_i) begin
                        rl_next = GST2_REMS;
                    end
                end
                GST2_REMS: begin
                    if (llo_i) begin
                        rl_next = GST2_RWLS;
                    end else if (gtl_i && listen_addr_i) begin
                        rl_next = GST2_LOCS;
                    end
                end
                GST2_RWLS: begin
                    if (gtl_i && listen_addr_i) begin
                        rl_next = GST2_LWLS;
                    end
                end
                GST2_LWLS: begin
                    if (listen_addr_i && !gtl_i) begin
                        rl_next = GST2_RWLS;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rl_reg <= GST2_LOCS;
        end else begin
            rl_reg <= rl_next;
        end
    end

    // Levels follow the state only; reads never touch them
    logic                   lockout_reg;
    logic                   remote_reg;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            lockout_reg <= 1'b0;
            remote_reg  <= 1'b0;
        end else begin
            lockout_reg <= (rl_next == GST2_LWLS) || (rl_next == GST2_RWLS);
            remote_reg  <= (rl_next == GST2_REMS) || (rl_next == GST2_RWLS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read image and interrupt

    logic [DATA_W-1:0]      rd_data_reg;
    logic                   irq_reg;

    // Snapshot at read start keeps the image stable for a long access
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_data_reg <= STAT_RESET;
        end else if (rd_start) begin
            rd_data_reg           <= STAT_RESET;
            rd_data_reg[BIT_SRV_REQ] <= srv_req_reg;
            rd_data_reg[BIT_LOCKOUT] <= lockout_reg;
            rd_data_reg[BIT_REMOTE]  <= remote_reg;
            rd_data_reg[BIT_CMD_OUT] <= cmd_out_reg;
        end
    end

    // Lockout deliberately has no enable and no path here
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (srv_req_reg & srv_req_ie_reg)
                     | (cmd_out_reg & cmd_out_ie_reg);
        end
    end

    assign rd_data_o                 = rd_data_reg;
    assign service_request_in_flag_o = srv_req_reg;
    assign command_out_flag_o        = cmd_out_reg;
    assign lockout_level_o           = lockout_reg;
    assign remote_level_o            = remote_reg;
    assign irq_o              = irq_reg;

endmodule
